// *** test/tb.sv ***
/*
  Self-checking bench for the match based pulse width modulation unit.
  Assumes the top module mbp_pwm_top, a 125 MHz clock and an AXI4-Lite
  master made of tasks here; no partner model.
*/
`timescale 1ns/1ns
`default_nettype none
module tb
  import mbp_pkg::*;
;
  logic        ref_clk_in = 1'b0;
  logic        rst_in     = 1'b1;
  logic        awvalid    = 1'b0;
  logic        wvalid     = 1'b0;
  logic        bready     = 1'b0;
  logic        arvalid    = 1'b0;
  logic        rready     = 1'b0;
  logic [7:0]  awaddr     = 8'h00;
  logic [7:0]  araddr     = 8'h00;
  logic [31:0] wdata      = 32'h0000_0000;
  logic [3:0]  wstrb      = 4'h0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, rd;
  logic [5:0]  pwm;
  int          fail_count = 0;
  int          tests_run  = 0;
  integer      hi [6];
  integer      ov35, ov15;

  // device under test, no input tied
  mbp_pwm_top DUT (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .s_axil_awvalid_in(awvalid), .s_axil_awready_out(awready), .s_axil_awaddr_in(awaddr),
    .s_axil_wvalid_in(wvalid), .s_axil_wready_out(wready), .s_axil_wdata_in(wdata),
    .s_axil_wstrb_in(wstrb), .s_axil_bvalid_out(bvalid), .s_axil_bready_in(bready),
    .s_axil_bresp_out(bresp), .s_axil_arvalid_in(arvalid), .s_axil_arready_out(arready),
    .s_axil_araddr_in(araddr), .s_axil_rvalid_out(rvalid), .s_axil_rready_in(rready),
    .s_axil_rdata_out(rdata), .s_axil_rresp_out(rresp), .pwm_out(pwm), .irq_out(irq)
  );

  // free running clock, 8 ns period
  always #4 ref_clk_in = ~ref_clk_in;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic print_verdict();
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  // write one word; address and data offered together, each released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int   n;
    logic aw_p, w_p;
    @(posedge ref_clk_in);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    aw_p = 1'b1;
    w_p  = 1'b1;
    n    = 0;
    do begin
      @(posedge ref_clk_in);
      n++;
      if (aw_p && awready === 1'b1) begin
        aw_p = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_p && wready === 1'b1) begin
        w_p = 1'b0;
        wvalid <= 1'b0;
      end
    end while ((aw_p || w_p || bvalid !== 1'b1) && n < 100);
    chk({30'h0, bresp}, {30'h0, er});
    if (n >= 100) fail_count++;
    bready <= 1'b0;
  endtask : axi_wr

  // read one word, check the response code, hand back the data
  task automatic axi_rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    int   n;
    logic ar_p;
    @(posedge ref_clk_in);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    ar_p = 1'b1;
    n    = 0;
    do begin
      @(posedge ref_clk_in);
      n++;
      if (ar_p && arready === 1'b1) begin
        ar_p = 1'b0;
        arvalid <= 1'b0;
      end
    end while ((ar_p || rvalid !== 1'b1) && n < 100);
    d = rdata;
    chk({30'h0, rresp}, {30'h0, er});
    if (n >= 100) fail_count++;
    rready <= 1'b0;
  endtask : axi_rd

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    axi_rd(a, RESP_OKAY, v);
    chk(v, exp);
  endtask : rd_chk

  // count high cycles of each output over three periods of ten counts
  task automatic measure();
    hi   = '{default: 0};
    ov35 = 0;
    ov15 = 0;
    repeat (30) begin
      @(negedge ref_clk_in);
      for (int k = 0; k < 6; k++) hi[k] += {31'h0, pwm[k]};
      ov35 += {31'h0, pwm[2] & pwm[4]};
      ov15 += {31'h0, pwm[0] & pwm[4]};
    end
  endtask : measure

  // watchdog cuts a hang short
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    fail_count++;
    print_verdict();
  end

  // main sequence
  initial begin
    repeat (20) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    // reset values and bus errors
    for (int a = 4; a <= 8'h3c; a += 4) begin
      if (a != 8) rd_chk(8'(a), RST_WORD);
    end
    axi_wr(8'h40, 32'h1, RESP_SLVERR);
    axi_rd(8'h40, RESP_SLVERR, rd);
    chk(rd, 32'h0);
    axi_rd(8'h06, RESP_SLVERR, rd);
    axi_wr(ADDR_COUNT, 32'h55, RESP_OKAY);
    rd_chk(ADDR_COUNT, 32'h0);
    axi_wr(ADDR_OUTCFG, 32'hffff_ffff, RESP_OKAY);
    rd_chk(ADDR_OUTCFG, {17'h0, OUTCFG_MASK});
    // modulation set-up: period 10, singles on 1 and 2, doubles on 3 and 5
    axi_wr(ADDR_MATCH0, 32'd9, RESP_OKAY);
    axi_wr(ADDR_MATCH0 + 8'h04, 32'd3, RESP_OKAY);
    axi_wr(ADDR_MATCH0 + 8'h08, 32'd2, RESP_OKAY);
    axi_wr(ADDR_MATCH0 + 8'h0c, 32'd6, RESP_OKAY);
    axi_wr(ADDR_MATCH0 + 8'h10, 32'd7, RESP_OKAY);
    axi_wr(ADDR_MATCH0 + 8'h14, 32'd1, RESP_OKAY);
    rd_chk(ADDR_MATCH0 + 8'h14, 32'd1);
    axi_wr(ADDR_OUTCFG, 32'h0000_2e28, RESP_OKAY);
    axi_wr(ADDR_RELEASE, 32'h7f, RESP_OKAY);
    axi_wr(ADDR_PRESCALE, 32'h0, RESP_OKAY);
    axi_wr(ADDR_ACTION, 32'h1, RESP_OKAY);
    axi_wr(ADDR_CTRL, 32'h9, RESP_OKAY);
    repeat (40) @(posedge ref_clk_in);
    measure();
    chk(hi[0], 12);
    chk(hi[1], 9);
    chk(hi[2], 12);
    chk(hi[3], 0);
    chk(hi[4], 12);
    chk(hi[5], 0);
    chk(ov35, 0);
    chk(ov15, 6);
    // masked interrupt stays low, unmasked rises
    chk(irq, 1'b0);
    axi_wr(ADDR_MASK, 32'h1, RESP_OKAY);
    repeat (12) @(negedge ref_clk_in);
    chk(irq, 1'b1);
    axi_wr(ADDR_MASK, 32'h0, RESP_OKAY);
    repeat (3) @(negedge ref_clk_in);
    chk(irq, 1'b0);
    // new value not used until released, then used from a period boundary
    axi_wr(ADDR_MATCH0 + 8'h04, 32'd5, RESP_OKAY);
    repeat (20) @(posedge ref_clk_in);
    measure();
    chk(hi[0], 12);
    axi_wr(ADDR_RELEASE, 32'h2, RESP_OKAY);
    repeat (20) @(posedge ref_clk_in);
    rd_chk(ADDR_RELEASE, 32'h0);
    measure();
    chk(hi[0], 18);
    chk(hi[2], 12);
    // plain timer: stop on match six, prescale by two
    axi_wr(ADDR_CTRL, 32'h2, RESP_OKAY);
    axi_rd(ADDR_STATUS, RESP_OKAY, rd);
    rd_chk(ADDR_STATUS, 32'h0);
    axi_wr(ADDR_ACTION, 32'h0014_0000, RESP_OKAY);
    axi_wr(ADDR_MATCH6, 32'h20, RESP_OKAY);
    axi_wr(ADDR_PRESCALE, 32'h1, RESP_OKAY);
    axi_wr(ADDR_MASK, 32'h40, RESP_OKAY);
    axi_wr(ADDR_CTRL, 32'h1, RESP_OKAY);
    repeat (4) @(negedge ref_clk_in);
    chk({26'h0, pwm}, 32'h0);
    repeat (150) @(posedge ref_clk_in);
    rd_chk(ADDR_COUNT, 32'h20);
    rd_chk(ADDR_CTRL, 32'h0);
    chk(irq, 1'b1);
    rd_chk(ADDR_STATUS, 32'h40);
    rd_chk(ADDR_STATUS, 32'h0);
    repeat (2) @(negedge ref_clk_in);
    chk(irq, 1'b0);
    // reset on match keeps the count at or below the match value
    axi_wr(ADDR_ACTION, 32'h000c_0000, RESP_OKAY);
    axi_wr(ADDR_PRESCALE, 32'h0, RESP_OKAY);
    axi_wr(ADDR_CTRL, 32'h1, RESP_OKAY);
    repeat (50) @(posedge ref_clk_in);
    for (int i = 0; i < 4; i++) begin
      axi_rd(ADDR_COUNT, RESP_OKAY, rd);
      chk({31'h0, rd <= 32'h20}, 32'h1);
    end
    rd_chk(ADDR_CTRL, 32'h1);
    rd_chk(ADDR_STATUS, 32'h40);
    axi_wr(ADDR_CTRL, 32'h0, RESP_OKAY);
    print_verdict();
  end
endmodule : tb
`default_nettype wire

// *** verilog/mbp_axil_port.sv ***
/*
  AXI4-Lite slave front end: takes address and data in either order, hands
  one-cycle write and read strobes to the register file, returns responses.
  Assumes the register file answers read data and errors combinationally.
*/
`timescale 1ns/1ns
`default_nettype none
module mbp_axil_port
  import mbp_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  input  wire logic        s_axil_awvalid_in,
  output var  logic        s_axil_awready_out,
  input  wire logic [7:0]  s_axil_awaddr_in,
  input  wire logic        s_axil_wvalid_in,
  output var  logic        s_axil_wready_out,
  input  wire logic [31:0] s_axil_wdata_in,
  input  wire logic [3:0]  s_axil_wstrb_in,
  output var  logic        s_axil_bvalid_out,
  input  wire logic        s_axil_bready_in,
  output var  logic [1:0]  s_axil_bresp_out,
  input  wire logic        s_axil_arvalid_in,
  output var  logic        s_axil_arready_out,
  input  wire logic [7:0]  s_axil_araddr_in,
  output var  logic        s_axil_rvalid_out,
  input  wire logic        s_axil_rready_in,
  output var  logic [31:0] s_axil_rdata_out,
  output var  logic [1:0]  s_axil_rresp_out,
  output var  mbp_wr_req_t wr_req_out,
  output var  logic        wr_en_out,
  input  wire logic        wr_err_in,
  output var  mbp_rd_req_t rd_req_out,
  output var  logic        rd_en_out,
  input  wire logic [31:0] rd_data_in,
  input  wire logic        rd_err_in
);
  // a channel holds its item while its ready is low
  assign wr_en_out = ~s_axil_awready_out & ~s_axil_wready_out & ~s_axil_bvalid_out;
  assign rd_en_out = ~s_axil_arready_out & ~s_axil_rvalid_out;

  // write address and data capture, then one response
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      s_axil_awready_out <= 1'b1;
      s_axil_wready_out  <= 1'b1;
      s_axil_bvalid_out  <= 1'b0;
      s_axil_bresp_out   <= RESP_OKAY;
      wr_req_out         <= '0;
    end else begin
      if (s_axil_awvalid_in && s_axil_awready_out) begin
        s_axil_awready_out <= 1'b0;
        wr_req_out.addr    <= s_axil_awaddr_in;
      end
      if (s_axil_wvalid_in && s_axil_wready_out) begin
        s_axil_wready_out <= 1'b0;
        wr_req_out.data   <= s_axil_wdata_in;
        wr_req_out.strb   <= s_axil_wstrb_in;
      end
      if (wr_en_out) begin
        s_axil_bvalid_out <= 1'b1;
        s_axil_bresp_out  <= wr_err_in ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axil_bvalid_out && s_axil_bready_in) begin
        s_axil_bvalid_out  <= 1'b0;
        s_axil_awready_out <= 1'b1;
        s_axil_wready_out  <= 1'b1;
      end
    end
  end

  // read address capture, data sampled one cycle later
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      s_axil_arready_out <= 1'b1;
      s_axil_rvalid_out  <= 1'b0;
      s_axil_rdata_out   <= RST_WORD;
      s_axil_rresp_out   <= RESP_OKAY;
      rd_req_out         <= '0;
    end else begin
      if (s_axil_arvalid_in && s_axil_arready_out) begin
        s_axil_arready_out <= 1'b0;
        rd_req_out.addr    <= s_axil_araddr_in;
      end
      if (rd_en_out) begin
        s_axil_rvalid_out <= 1'b1;
        s_axil_rdata_out  <= rd_data_in;
        s_axil_rresp_out  <= rd_err_in ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axil_rvalid_out && s_axil_rready_in) begin
        s_axil_rvalid_out  <= 1'b0;
        s_axil_arready_out <= 1'b1;
      end
    end
  end
endmodule : mbp_axil_port
`default_nettype wire

// *** verilog/mbp_pkg.sv ***
/*
  Constants, register map, field layout and bus carrier types for the
  match based pulse width modulation unit.
  Assumes a single 125 MHz clock and an AXI4-Lite master with 32-bit data.
*/
// Contract
// RULE1: counter steps on clock cycles through a 32-bit prescaler; counter is 32 bits.
// RULE2: period match restarts the counter whenever the count equals its value.
// RULE3: seven match registers drive six single or three double edge outputs, or a mix.
// RULE4: each single edge output uses one extra match register for its falling edge.
// RULE5: single edge outputs rise at every period match unless held constantly low.
// RULE6: each double edge output uses two match registers, one per edge.
// RULE7: rising match first gives a high pulse; falling match first gives a low pulse.
// RULE8: all outputs share one repetition rate set only by the period match.
// RULE9: period and width are any whole number of timer counts.
// RULE10: each match may raise an interrupt, stop the timer or reset it.
// RULE11: new match values apply in step with pulses, only after software releases them.
// RULE12: with modulation off the unit is a plain timer with the same match logic.
// RULE13: released values load into the comparators only at the next period match.
// RULE14: reset on match zeroes counter and prescaler on the next clock, then counts on.
`default_nettype none
package mbp_pkg;
  localparam int unsigned NUM_MATCH = 7;
  localparam int unsigned NUM_OUT   = 6;
  localparam int unsigned ACT_W     = 3;
  // register byte addresses
  localparam logic [7:0] ADDR_STATUS   = 8'h00;
  localparam logic [7:0] ADDR_CTRL     = 8'h04;
  localparam logic [7:0] ADDR_COUNT    = 8'h08;
  localparam logic [7:0] ADDR_PRESCALE = 8'h0c;
  localparam logic [7:0] ADDR_PRECOUNT = 8'h10;
  localparam logic [7:0] ADDR_ACTION   = 8'h14;
  localparam logic [7:0] ADDR_MATCH0   = 8'h18;
  localparam logic [7:0] ADDR_MATCH6   = 8'h30;
  localparam logic [7:0] ADDR_OUTCFG   = 8'h34;
  localparam logic [7:0] ADDR_RELEASE  = 8'h38;
  localparam logic [7:0] ADDR_MASK     = 8'h3c;
  // control fields
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned CTRL_CLR_BIT = 1;
  localparam int unsigned CTRL_PWM_BIT = 3;
  // per-match action fields, three bits per match
  localparam int unsigned ACT_IRQ_OFS  = 0;
  localparam int unsigned ACT_RST_OFS  = 1;
  localparam int unsigned ACT_STOP_OFS = 2;
  // output config: bit k selects double edge for output k, bit 8+k enables it
  localparam int unsigned OUTCFG_EN_OFS = 8;
  localparam logic [14:0] OUTCFG_MASK   = 15'h7e7c;
  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [6:0]  RST_FLAG = 7'h00;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } mbp_wr_req_t;

  typedef struct packed {
    logic [7:0] addr;
  } mbp_rd_req_t;
endpackage : mbp_pkg
`default_nettype wire

// *** verilog/mbp_pwm_top.sv ***
/*
  Match based pulse width modulation unit: 32-bit prescaler and counter,
  seven match registers with shadow copies, six outputs, interrupt logic.
  Assumes one 125 MHz clock, synchronous active-high reset, AXI4-Lite master.
*/
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module mbp_pwm_top
  import mbp_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  input  wire logic        s_axil_awvalid_in,
  output var  logic        s_axil_awready_out,
  input  wire logic [7:0]  s_axil_awaddr_in,
  input  wire logic        s_axil_wvalid_in,
  output var  logic        s_axil_wready_out,
  input  wire logic [31:0] s_axil_wdata_in,
  input  wire logic [3:0]  s_axil_wstrb_in,
  output var  logic        s_axil_bvalid_out,
  input  wire logic        s_axil_bready_in,
  output var  logic [1:0]  s_axil_bresp_out,
  input  wire logic        s_axil_arvalid_in,
  output var  logic        s_axil_arready_out,
  input  wire logic [7:0]  s_axil_araddr_in,
  output var  logic        s_axil_rvalid_out,
  input  wire logic        s_axil_rready_in,
  output var  logic [31:0] s_axil_rdata_out,
  output var  logic [1:0]  s_axil_rresp_out,
  output var  logic [5:0]  pwm_out,
  output var  logic        irq_out
);
  // true for any byte address that holds a register
  function automatic logic is_mapped(input logic [7:0] a);
    logic ok;
    ok = (a[1:0] == 2'b00) && (a <= ADDR_MASK);
    return ok;
  endfunction : is_mapped

  // index of a match register from its address
  function automatic logic [2:0] match_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - ADDR_MATCH0;
    return d[4:2];
  endfunction : match_idx

  // merge written bytes into an old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction : merge

  mbp_wr_req_t wr_req;
  mbp_rd_req_t rd_req;
  logic        wr_en;
  logic        rd_en;
  logic [31:0] rd_data;
  logic        rd_err;
  logic        wr_err;
  logic [31:0] wr_word;

  logic        run_q;
  logic        clr_q;
  logic        pwm_en_q;
  logic [31:0] tc_q;
  logic [31:0] pc_q;
  logic [31:0] pr_q;
  logic [20:0] act_q;
  logic [14:0] outcfg_q;
  logic [6:0]  latch_q;
  logic [6:0]  status_q;
  logic [6:0]  mask_q;
  logic [31:0] shd_q [NUM_MATCH];
  logic [31:0] mr_q  [NUM_MATCH];

  logic        tick;
  logic [6:0]  match;
  logic [6:0]  act_irq;
  logic [6:0]  act_rst;
  logic [6:0]  act_stop;
  logic        cnt_reset;
  logic        cnt_stop;
  logic        wr_match;
  logic        rd_status;

  mbp_axil_port u_port (
    .ref_clk_in         (ref_clk_in),
    .rst_in             (rst_in),
    .s_axil_awvalid_in  (s_axil_awvalid_in),
    .s_axil_awready_out (s_axil_awready_out),
    .s_axil_awaddr_in   (s_axil_awaddr_in),
    .s_axil_wvalid_in   (s_axil_wvalid_in),
    .s_axil_wready_out  (s_axil_wready_out),
    .s_axil_wdata_in    (s_axil_wdata_in),
    .s_axil_wstrb_in    (s_axil_wstrb_in),
    .s_axil_bvalid_out  (s_axil_bvalid_out),
    .s_axil_bready_in   (s_axil_bready_in),
    .s_axil_bresp_out   (s_axil_bresp_out),
    .s_axil_arvalid_in  (s_axil_arvalid_in),
    .s_axil_arready_out (s_axil_arready_out),
    .s_axil_araddr_in   (s_axil_araddr_in),
    .s_axil_rvalid_out  (s_axil_rvalid_out),
    .s_axil_rready_in   (s_axil_rready_in),
    .s_axil_rdata_out   (s_axil_rdata_out),
    .s_axil_rresp_out   (s_axil_rresp_out),
    .wr_req_out         (wr_req),
    .wr_en_out          (wr_en),
    .wr_err_in          (wr_err),
    .rd_req_out         (rd_req),
    .rd_en_out          (rd_en),
    .rd_data_in         (rd_data),
    .rd_err_in          (rd_err)
  );

  // register read mux and address checks
  always_comb begin
    rd_err = ~is_mapped(rd_req.addr);
    wr_err = ~is_mapped(wr_req.addr);
    rd_data = RST_WORD;
    case (rd_req.addr)
      ADDR_STATUS:   rd_data = {25'h0, status_q};
      ADDR_CTRL:     rd_data = {28'h0, pwm_en_q, 1'b0, clr_q, run_q};
      ADDR_COUNT:    rd_data = tc_q;
      ADDR_PRESCALE: rd_data = pr_q;
      ADDR_PRECOUNT: rd_data = pc_q;
      ADDR_ACTION:   rd_data = {11'h0, act_q};
      ADDR_OUTCFG:   rd_data = {17'h0, outcfg_q};
      ADDR_RELEASE:  rd_data = {25'h0, latch_q};
      ADDR_MASK:     rd_data = {25'h0, mask_q};
      default: begin
        if (rd_req.addr >= ADDR_MATCH0 && rd_req.addr <= ADDR_MATCH6) begin
          rd_data = shd_q[match_idx(rd_req.addr)];
        end
      end
    endcase
  end

  assign wr_word   = merge(RST_WORD, wr_req.data, wr_req.strb);
  assign wr_match  = wr_en && wr_req.addr >= ADDR_MATCH0 && wr_req.addr <= ADDR_MATCH6;
  assign rd_status = rd_en && rd_req.addr == ADDR_STATUS;

  // match detection and per-match actions
  assign tick = (pc_q == pr_q); // RULE1
  always_comb begin
    for (int i = 0; i < NUM_MATCH; i++) begin
      match[i]    = run_q && !clr_q && tick && (tc_q == mr_q[i]); // RULE3 RULE9
      act_irq[i]  = act_q[i*ACT_W + ACT_IRQ_OFS];
      act_rst[i]  = act_q[i*ACT_W + ACT_RST_OFS];
      act_stop[i] = act_q[i*ACT_W + ACT_STOP_OFS];
    end
  end
  assign cnt_reset = |(match & act_rst) || (pwm_en_q && match[0]); // RULE2 RULE10 RULE12
  assign cnt_stop  = |(match & act_stop); // RULE10

  // control register: run, hold in reset, modulation mode
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      run_q    <= 1'b0;
      clr_q    <= 1'b0;
      pwm_en_q <= 1'b0;
    end else if (wr_en && wr_req.addr == ADDR_CTRL && wr_req.strb[0]) begin
      run_q    <= wr_req.data[CTRL_RUN_BIT];
      clr_q    <= wr_req.data[CTRL_CLR_BIT];
      pwm_en_q <= wr_req.data[CTRL_PWM_BIT];
    end else if (cnt_stop) begin
      run_q <= 1'b0; // RULE10
    end
  end

  // prescaler and counter
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || clr_q) begin
      tc_q <= RST_WORD;
      pc_q <= RST_WORD;
    end else if (run_q) begin
      if (tick) begin
        pc_q <= RST_WORD;
        // a stop without reset leaves the count parked on its match value
        if (cnt_reset) begin
          tc_q <= RST_WORD; // RULE2 RULE14
        end else if (!cnt_stop) begin
          tc_q <= tc_q + 32'h1; // RULE1 RULE10
        end
      end else begin
        pc_q <= pc_q + 32'h1; // RULE1
      end
    end
  end

  // plain configuration registers
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      pr_q     <= RST_WORD;
      act_q    <= 21'h0;
      outcfg_q <= 15'h0;
      mask_q   <= RST_FLAG;
    end else if (wr_en) begin
      case (wr_req.addr)
        ADDR_PRESCALE: pr_q <= merge(pr_q, wr_req.data, wr_req.strb);
        ADDR_ACTION:   act_q <= 21'(merge({11'h0, act_q}, wr_req.data, wr_req.strb));
        ADDR_OUTCFG:   outcfg_q <= 15'(merge({17'h0, outcfg_q}, wr_req.data, wr_req.strb))
                                   & OUTCFG_MASK;
        ADDR_MASK:     mask_q <= 7'(merge({25'h0, mask_q}, wr_req.data, wr_req.strb));
        default: begin
        end
      endcase
    end
  end

  // shadow match values written by software
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < NUM_MATCH; i++) shd_q[i] <= RST_WORD;
    end else if (wr_match) begin
      shd_q[match_idx(wr_req.addr)] <= merge(shd_q[match_idx(wr_req.addr)], wr_req.data,
                                             wr_req.strb);
    end
  end

  // release flags: a new release beats the transfer clear in the same cycle
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      latch_q <= RST_FLAG;
    end else begin
      latch_q <= (latch_q & ~((pwm_en_q && match[0]) ? latch_q : RST_FLAG))
                 | ((wr_en && wr_req.addr == ADDR_RELEASE) ? wr_word[6:0] : RST_FLAG); // RULE11
    end
  end

  // active comparator values
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < NUM_MATCH; i++) mr_q[i] <= RST_WORD;
    end else begin
      for (int i = 0; i < NUM_MATCH; i++) begin
        if (!pwm_en_q) begin
          mr_q[i] <= shd_q[i]; // RULE12
        end else if (match[0] && latch_q[i]) begin
          mr_q[i] <= shd_q[i]; // RULE11 RULE13
        end
      end
    end
  end

  // outputs: output k rises on its set match and falls on match k, fall wins
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      pwm_out <= 6'h00;
    end else begin
      for (int k = 1; k <= NUM_OUT; k++) begin
        if (!pwm_en_q || !outcfg_q[OUTCFG_EN_OFS + k]) begin
          pwm_out[k-1] <= 1'b0;
        end else if (match[k]) begin
          pwm_out[k-1] <= 1'b0; // RULE4 RULE6 RULE7
        end else if (outcfg_q[k] ? match[k-1] : match[0]) begin
          pwm_out[k-1] <= 1'b1; // RULE5 RULE6 RULE7 RULE8
        end
      end
    end
  end

  // sticky status: a match event beats the read clear
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      status_q <= RST_FLAG;
    end else begin
      status_q <= (rd_status ? RST_FLAG : status_q) | (match & act_irq); // RULE10
    end
  end

  // interrupt level, one cycle behind status and mask
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(status_q & mask_q);
    end
  end

  default clocking mbp_cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);

  // counter, prescaler and match actions
  a_period_restart: assert property (pwm_en_q && match[0] && !cnt_stop && !clr_q // RULE2
    |=> tc_q == 32'h0 && pc_q == 32'h0)
    else $error("period match did not restart");
  a_prescale_hold: assert property (run_q && !clr_q && !tick && !wr_en // RULE1
    |=> tc_q == $past(tc_q) && pc_q == $past(pc_q) + 32'h1)
    else $error("counter moved without prescale tick");
  a_count_step: assert property (run_q && !clr_q && tick && !cnt_reset && !cnt_stop // RULE1
    |=> tc_q == $past(tc_q) + 32'h1 && pc_q == 32'h0)
    else $error("counter did not step on tick");
  a_clear_hold: assert property (clr_q // RULE1
    |=> tc_q == 32'h0 && pc_q == 32'h0)
    else $error("held counter not at zero");
  a_reset_match: assert property (|(match & act_rst) && !clr_q // RULE14
    |=> tc_q == 32'h0 && pc_q == 32'h0)
    else $error("reset on match missed");
  a_stop_match: assert property (cnt_stop && !(wr_en && wr_req.addr == ADDR_CTRL) // RULE10
    |=> !run_q ##1 (!run_q || $past(wr_en && wr_req.addr == ADDR_CTRL)))
    else $error("stop on match missed");
  a_stop_hold: assert property (cnt_stop && !cnt_reset // RULE10
    |=> tc_q == $past(tc_q))
    else $error("stopped counter moved past match");

  // modulation outputs
  a_single_rise: assert property (pwm_en_q && outcfg_q[OUTCFG_EN_OFS + 1] // RULE5
    && match[0] && !match[1] |=> pwm_out[0])
    else $error("single edge output did not rise");
  a_single_fall: assert property (pwm_en_q && match[1] // RULE4
    |=> !pwm_out[0])
    else $error("single edge output did not fall");
  a_double_rise: assert property (pwm_en_q && outcfg_q[OUTCFG_EN_OFS + 3] // RULE6
    && outcfg_q[3] && match[2] && !match[3] |=> pwm_out[2])
    else $error("double edge rise missed");
  a_double_fall: assert property (pwm_en_q && match[3] // RULE7
    |=> !pwm_out[2])
    else $error("double edge fall missed");
  a_out_hold: assert property (pwm_en_q && match == 7'h00 && $stable(outcfg_q) // RULE8
    |=> $stable(pwm_out))
    else $error("output moved without a match");
  a_out_off: assert property (!pwm_en_q // RULE12
    |=> pwm_out == 6'h00)
    else $error("output active in timer mode");

  // shadow transfer and release
  a_shadow_hold: assert property (pwm_en_q && !match[0] && $stable(pwm_en_q) // RULE13
    |=> mr_q[3] == $past(mr_q[3]))
    else $error("match value changed mid cycle");
  a_release_keep: assert property (pwm_en_q && !match[0] && latch_q[1] // RULE11
    |=> latch_q[1])
    else $error("pending release lost before period match");
  a_release_load: assert property (pwm_en_q && match[0] && latch_q[1] // RULE13
    |=> mr_q[1] == $past(shd_q[1]))
    else $error("released value not loaded at period match");
  a_timer_copy: assert property (!pwm_en_q ##1 !pwm_en_q // RULE12
    |-> mr_q[1] == $past(shd_q[1]))
    else $error("timer mode comparator stale");

  // status and interrupt
  a_status_set: assert property (match[0] && act_irq[0] // RULE10
    |=> status_q[0] ##1 (irq_out || !$past(mask_q[0])))
    else $error("match interrupt not flagged");
  a_status_keep: assert property (status_q[6] && !rd_status // RULE10
    |=> status_q[6])
    else $error("sticky status bit lost");
  a_status_clear: assert property (rd_status && !(match[6] && act_irq[6]) // RULE10
    |=> !status_q[6])
    else $error("status read did not clear");
  a_irq_follow: assert property (irq_out == $past(|(status_q & mask_q))) // RULE10
    else $error("interrupt level wrong");
endmodule : mbp_pwm_top
`default_nettype wire
